// *** hw/spcs_defs.svh ***
// spcs_defs.svh: offsets, field positions, reset values and timing counts
// for the serial-port control/status register bank.
// assumes: included by bare name from the package and design modules.
`ifndef SPCS_DEFS_SVH
`define SPCS_DEFS_SVH

// register offsets on the serial control port
`define SPCS_ADDR_W 12
`define SPCS_ADDR_CFG2 12'h001
`define SPCS_ADDR_STAT 12'h002
`define SPCS_ADDR_UPD 12'h00f

// value that, written to the update register, applies pending fields
`define SPCS_UPD_KEY 8'h01

// second configuration register field positions
`define SPCS_CFG2_SINGLE 7
`define SPCS_CFG2_RDBUF 5
`define SPCS_CFG2_TUNE 2
`define SPCS_CFG2_DIVRST 1

// status register field positions
`define SPCS_STAT_LOCK 7
`define SPCS_STAT_REF 6
`define SPCS_STAT_FB 5
`define SPCS_STAT_BOTH 4
`define SPCS_STAT_SLEEP_HI 1
`define SPCS_STAT_SLEEP_LO 0

// reset values
`define SPCS_CFG2_RESET 8'h00
`define SPCS_SLEEP_RESET 2'h0
`define SPCS_SLEEP_ON 2'h3

// sequencer timing counts in clk cycles
`define SPCS_CNT_W 8
`define SPCS_TUNE_CYCLES 8'hc8
`define SPCS_STALL_CYCLES 8'h04
`define SPCS_DIVRST_CYCLES 8'h08

`endif

// *** hw/spcs_pkg.sv ***
// spcs_pkg: types shared by the register bank and its restart sequencer.
// assumes: spcs_defs.svh is reachable on the include path.
`include "spcs_defs.svh"

package spcs_pkg;

   // sequencer phases
   typedef enum logic [1:0] {
      SPCS_SEQ_IDLE = 2'b00,
      SPCS_SEQ_TUNE = 2'b01,
      SPCS_SEQ_STALL = 2'b10,
      SPCS_SEQ_DIVRST = 2'b11
   } spcs_seq_state_t;

   // register access from the serial port engine
   typedef struct packed {
      logic [`SPCS_ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } spcs_acc_t;

   // sequencer outputs toward the clock datapath
   typedef struct packed {
      logic tune_busy;
      logic div_busy;
      logic osc_tune;
      logic out_stall;
      logic div_reset;
   } spcs_seq_out_t;

   // sequencer state
   typedef struct packed {
      spcs_seq_state_t st;
      logic [`SPCS_CNT_W-1:0] cnt;
      spcs_seq_out_t out;
   } spcs_seq_t;

   // register bank state
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [2:0] lock_sync;
      logic [2:0] ref_sync;
      logic [2:0] fb_sync;
      logic single_instr;
      logic rdbuf_act;
      logic rdbuf_pend;
      logic [1:0] sleep_act;
      logic [1:0] sleep_pend;
      logic tune_req;
      logic div_req;
      logic upd_pulse;
      logic [7:0] rdata;
      logic rvalid;
   } spcs_regs_t;

endpackage : spcs_pkg

// *** hw/spcs_seq.sv ***
// spcs_seq: oscillator tune and divider restart sequencer.
// assumes: synchronous active-low reset already released through flops.
`timescale 1ns/100ps
`default_nettype none
`include "spcs_defs.svh"

module spcs_seq #(
   parameter logic [`SPCS_CNT_W-1:0] TUNE_CYCLES = `SPCS_TUNE_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] STALL_CYCLES = `SPCS_STALL_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] DIVRST_CYCLES = `SPCS_DIVRST_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_clr,
   input wire logic tune_req,
   input wire logic div_req,
   output spcs_pkg::spcs_seq_out_t seq_out
);

   spcs_pkg::spcs_seq_t s_reg;
   spcs_pkg::spcs_seq_t s_next;

   // phase walk: tune, then stall, then divider reset, then release
   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         spcs_pkg::SPCS_SEQ_IDLE: begin
            if (tune_req) begin
               s_next.st = spcs_pkg::SPCS_SEQ_TUNE;
               s_next.cnt = TUNE_CYCLES;
            end else if (div_req) begin
               s_next.st = spcs_pkg::SPCS_SEQ_STALL;
               s_next.cnt = STALL_CYCLES;
            end
         end
         spcs_pkg::SPCS_SEQ_TUNE: begin
            if (s_reg.cnt <= 8'h01) begin
               // tuning always chains into the full restart
               s_next.st = spcs_pkg::SPCS_SEQ_STALL;
               s_next.cnt = STALL_CYCLES;
            end else begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         spcs_pkg::SPCS_SEQ_STALL: begin
            if (s_reg.cnt <= 8'h01) begin
               s_next.st = spcs_pkg::SPCS_SEQ_DIVRST;
               s_next.cnt = DIVRST_CYCLES;
            end else begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         spcs_pkg::SPCS_SEQ_DIVRST: begin
            if (s_reg.cnt <= 8'h01) begin
               s_next.st = spcs_pkg::SPCS_SEQ_IDLE; // outputs re-enabled
               s_next.cnt = '0;
            end else begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
      endcase
      // soft reset abandons any sequence in flight
      if (soft_clr) begin
         s_next.st = spcs_pkg::SPCS_SEQ_IDLE;
         s_next.cnt = '0;
      end
      // outputs registered from the next phase; tune_busy spans tuning and the restart after it
      s_next.out.osc_tune = (s_next.st == spcs_pkg::SPCS_SEQ_TUNE);
      s_next.out.tune_busy = (s_next.st == spcs_pkg::SPCS_SEQ_TUNE)
         || (s_reg.out.tune_busy
             && s_next.st != spcs_pkg::SPCS_SEQ_IDLE);
      s_next.out.div_busy = (s_next.st == spcs_pkg::SPCS_SEQ_STALL)
         || (s_next.st == spcs_pkg::SPCS_SEQ_DIVRST);
      s_next.out.out_stall = s_next.out.div_busy;
      s_next.out.div_reset = (s_next.st == spcs_pkg::SPCS_SEQ_DIVRST);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign seq_out = s_reg.out;

endmodule : spcs_seq
`default_nettype wire

// *** hw/spcs_regs.sv ***
// spcs_regs: second serial-port configuration register and loop status
// register, with pending/active copies and the restart sequencer.
// assumes: one-cycle access strobes from the serial port engine on clk;
// lock and detector levels arrive from the analog loop, unsynchronised.
`timescale 1ns/100ps
`default_nettype none
`include "spcs_defs.svh"

module spcs_regs #(
   parameter logic [`SPCS_CNT_W-1:0] TUNE_CYCLES = `SPCS_TUNE_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] STALL_CYCLES = `SPCS_STALL_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] DIVRST_CYCLES = `SPCS_DIVRST_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire spcs_pkg::spcs_acc_t acc,
   input wire logic pll_locked_in,
   input wire logic ref_detect_in,
   input wire logic fb_detect_in,
   output logic [7:0] acc_rdata,
   output logic acc_rvalid,
   output logic single_instr,
   output logic [1:0] sleep_mode,
   output logic update_pulse,
   output spcs_pkg::spcs_seq_out_t seq_out
);

   spcs_pkg::spcs_regs_t r_reg;
   spcs_pkg::spcs_regs_t r_next;
   logic rst_n;
   logic lock_s;
   logic ref_s;
   logic fb_s;
   logic [1:0] sleep_rd;
   logic rdbuf_rd;
   logic busy;

   // released reset copy; only the second release flop is read, and
   // the rest of the bank clears synchronously while it is low
   assign rst_n = r_reg.rst_sync[1];

   // detector levels after the second sync flop, then one more stage
   // the extra stage costs a clock of latency but keeps the status
   // read away from a flop that may still be settling
   assign lock_s = r_reg.lock_sync[2];
   assign ref_s = r_reg.ref_sync[2];
   assign fb_s = r_reg.fb_sync[2];

   // which copy a read of a buffered field returns
   // a buffered bit changes only on update or soft reset, never on its own write
   assign sleep_rd = r_reg.rdbuf_act ? r_reg.sleep_pend : r_reg.sleep_act;
   assign rdbuf_rd = r_reg.rdbuf_act ? r_reg.rdbuf_pend : r_reg.rdbuf_act;
   // busy blocks new strobes; only a soft reset or resetn cuts a sequence short
   assign busy = seq_out.tune_busy | seq_out.div_busy;

   // register file next state
   // detector history shifts every clock, accesses or not
   always_comb begin
      r_next = r_reg;
      r_next.lock_sync = {r_reg.lock_sync[1:0], pll_locked_in};
      r_next.ref_sync = {r_reg.ref_sync[1:0], ref_detect_in};
      r_next.fb_sync = {r_reg.fb_sync[1:0], fb_detect_in};
      r_next.tune_req = 1'b0;
      r_next.div_req = 1'b0;
      r_next.upd_pulse = 1'b0;
      r_next.rvalid = 1'b0;
      if (acc.wr) begin
         unique case (acc.addr)
            `SPCS_ADDR_CFG2: begin
               r_next.single_instr = acc.wdata[`SPCS_CFG2_SINGLE];
               r_next.rdbuf_pend = acc.wdata[`SPCS_CFG2_RDBUF];
               // strobes are dropped while a sequence is running
               // and are lost, not queued: poll bits 2 and 1 before
               // asking again
               r_next.tune_req = acc.wdata[`SPCS_CFG2_TUNE] & ~busy;
               r_next.div_req = acc.wdata[`SPCS_CFG2_DIVRST] & ~busy;
            end
            `SPCS_ADDR_STAT: begin
               // only the sleep field is writable; 3:2 ignored
               // 01 and 10 are stored as written; sleep logic decides
               r_next.sleep_pend =
                  acc.wdata[`SPCS_STAT_SLEEP_HI:`SPCS_STAT_SLEEP_LO];
            end
            `SPCS_ADDR_UPD: begin
               // any other value leaves both copies alone
               if (acc.wdata == `SPCS_UPD_KEY) begin
                  r_next.sleep_act = r_reg.sleep_pend;
                  r_next.rdbuf_act = r_reg.rdbuf_pend;
                  r_next.upd_pulse = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (acc.rd) begin
         r_next.rvalid = 1'b1;
         // unmapped and write-only addresses read back zero
         // a read and a write in one cycle return the old contents
         r_next.rdata = 8'h00;
         unique case (acc.addr)
            `SPCS_ADDR_CFG2: begin
               r_next.rdata[`SPCS_CFG2_SINGLE] = r_reg.single_instr;
               r_next.rdata[`SPCS_CFG2_RDBUF] = rdbuf_rd;
               // strobe bits read 1 until their sequence ends
               // the request flop covers the clock before the start
               r_next.rdata[`SPCS_CFG2_TUNE] =
                  seq_out.tune_busy | r_reg.tune_req;
               // bit 1 tracks restart phases and the tune request flop; reads 0 while tuning
               r_next.rdata[`SPCS_CFG2_DIVRST] = seq_out.div_busy
                  | r_reg.div_req | r_reg.tune_req;
            end
            `SPCS_ADDR_STAT: begin
               // detector levels are three clocks old, so a read just
               // after reset may still show them low
               r_next.rdata[`SPCS_STAT_LOCK] = lock_s;
               r_next.rdata[`SPCS_STAT_REF] = ref_s;
               r_next.rdata[`SPCS_STAT_FB] = fb_s;
               r_next.rdata[`SPCS_STAT_BOTH] = ref_s & fb_s;
               r_next.rdata[`SPCS_STAT_SLEEP_HI:`SPCS_STAT_SLEEP_LO] =
                  sleep_rd;
            end
            default: begin
            end
         endcase
      end
      // soft reset returns every control field to its reset value; the
      // sequencer aborts on the same strobe, so no output stays stalled
      if (soft_reset) begin
         r_next.single_instr = 1'(`SPCS_CFG2_RESET >> `SPCS_CFG2_SINGLE);
         r_next.rdbuf_act = 1'b0;
         r_next.rdbuf_pend = 1'b0;
         r_next.sleep_act = `SPCS_SLEEP_RESET;
         r_next.sleep_pend = `SPCS_SLEEP_RESET;
         r_next.tune_req = 1'b0;
         r_next.div_req = 1'b0;
      end
      // release flops shift in ones; resetn clears them asynchronously
      r_next.rst_sync = {r_reg.rst_sync[0], 1'b1};
   end

   // one register for all state; resetn clears it at once, then the
   // release flops shift in ones while every other field stays at its
   // reset value, so the bank leaves reset on a clean clock edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
      end else if (!rst_n) begin
         r_reg.rst_sync <= r_next.rst_sync;
         r_reg.lock_sync <= 3'h0;
         r_reg.ref_sync <= 3'h0;
         r_reg.fb_sync <= 3'h0;
         r_reg.single_instr <= 1'b0;
         r_reg.rdbuf_act <= 1'b0;
         r_reg.rdbuf_pend <= 1'b0;
         r_reg.sleep_act <= `SPCS_SLEEP_RESET;
         r_reg.sleep_pend <= `SPCS_SLEEP_RESET;
         r_reg.tune_req <= 1'b0;
         r_reg.div_req <= 1'b0;
         r_reg.upd_pulse <= 1'b0;
         r_reg.rdata <= 8'h00;
         r_reg.rvalid <= 1'b0;
      end else begin
         r_reg.rst_sync <= r_next.rst_sync;
         r_reg.lock_sync <= r_next.lock_sync;
         r_reg.ref_sync <= r_next.ref_sync;
         r_reg.fb_sync <= r_next.fb_sync;
         r_reg.single_instr <= r_next.single_instr;
         r_reg.rdbuf_act <= r_next.rdbuf_act;
         r_reg.rdbuf_pend <= r_next.rdbuf_pend;
         r_reg.sleep_act <= r_next.sleep_act;
         r_reg.sleep_pend <= r_next.sleep_pend;
         r_reg.tune_req <= r_next.tune_req;
         r_reg.div_req <= r_next.div_req;
         r_reg.upd_pulse <= r_next.upd_pulse;
         r_reg.rdata <= r_next.rdata;
         r_reg.rvalid <= r_next.rvalid;
      end
   end

   // tuning and restart timing; tuning requests win over restarts
   // requests are one-cycle pulses, taken only while the sequencer idles
   spcs_seq #(
      .TUNE_CYCLES(TUNE_CYCLES),
      .STALL_CYCLES(STALL_CYCLES),
      .DIVRST_CYCLES(DIVRST_CYCLES)
   ) u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .soft_clr(soft_reset),
      .tune_req(r_reg.tune_req),
      .div_req(r_reg.div_req),
      .seq_out(seq_out)
   );

   // all outputs come straight from flops
   // read data hold until the next read, so the engine may sample late
   assign acc_rdata = r_reg.rdata;
   assign acc_rvalid = r_reg.rvalid;
   assign single_instr = r_reg.single_instr;
   assign sleep_mode = r_reg.sleep_act;
   assign update_pulse = r_reg.upd_pulse;

endmodule : spcs_regs
`default_nettype wire

// *** test/spcs_regs_assertions.sv ***
// spcs_regs_assertions: checker for the config-two/status bank.
// assumes: bound into spcs_regs, sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "spcs_defs.svh"
module spcs_regs_checker #(
   parameter logic [`SPCS_CNT_W-1:0] TUNE_CYCLES = `SPCS_TUNE_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] STALL_CYCLES = `SPCS_STALL_CYCLES,
   parameter logic [`SPCS_CNT_W-1:0] DIVRST_CYCLES = `SPCS_DIVRST_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic soft_reset,
   input wire spcs_pkg::spcs_acc_t acc,
   input wire logic pll_locked_in,
   input wire logic ref_detect_in,
   input wire logic fb_detect_in,
   input wire logic [7:0] acc_rdata,
   input wire logic acc_rvalid,
   input wire logic single_instr,
   input wire logic [1:0] sleep_mode,
   input wire logic update_pulse,
   input wire spcs_pkg::spcs_seq_out_t seq_out
);
   localparam int TC = TUNE_CYCLES;
   localparam int SC = STALL_CYCLES;
   localparam int DC = DIVRST_CYCLES;
   logic [5:0][2:0] hist;
   logic calm, upd_hit, cfg_wr, idle;
   // detector history: status judged only once inputs have settled
   always_ff @(posedge clk) begin
      hist <= {hist[4:0], {pll_locked_in, ref_detect_in, fb_detect_in}};
   end
   // decoded strobes
   assign calm = (hist == {6{hist[0]}});
   assign upd_hit = acc.wr && acc.addr == `SPCS_ADDR_UPD
      && acc.wdata == `SPCS_UPD_KEY;
   assign cfg_wr = acc.wr && acc.addr == `SPCS_ADDR_CFG2 && !soft_reset;
   assign idle = !seq_out.tune_busy && !seq_out.div_busy;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   read_answer_a: assert property (1 |=> acc_rvalid == $past(acc.rd))
      else $error("read strobe not answered in one cycle");
   status_bits_a: assert property (acc.rd && acc.addr == `SPCS_ADDR_STAT
      && calm |=> acc_rdata[7:5] == $past(hist[0]))
      else $error("status bits differ from detectors");
   both_bit_a: assert property (acc_rvalid && $past(acc.addr) ==
      `SPCS_ADDR_STAT |-> acc_rdata[4] == (acc_rdata[6] & acc_rdata[5]))
      else $error("combined status bit wrong");
   resv_zero_a: assert property (acc_rvalid && $past(acc.addr) ==
      `SPCS_ADDR_STAT |-> acc_rdata[3:2] == 2'h0)
      else $error("status bits 3:2 not zero");
   single_set_a: assert property (cfg_wr |=>
      single_instr == $past(acc.wdata[7]))
      else $error("single mode not taken at once");
   single_hold_a: assert property (!cfg_wr && !soft_reset |=>
      $stable(single_instr))
      else $error("single mode changed without write");
   update_a: assert property (1 |=> update_pulse == $past(upd_hit))
      else $error("update pulse not tied to key write");
   sleep_upd_a: assert property ($changed(sleep_mode) |->
      update_pulse || $past(soft_reset))
      else $error("sleep field changed without update");
   tune_start_a: assert property (cfg_wr && acc.wdata[2] && idle
      && !$past(cfg_wr) |-> ##2 seq_out.osc_tune && seq_out.tune_busy)
      else $error("tune did not start");
   tune_len_a: assert property ($rose(seq_out.osc_tune) |-> ##TC
      !seq_out.osc_tune && seq_out.out_stall)
      else $error("tune not followed by restart");
   div_start_a: assert property (cfg_wr && acc.wdata[2:1] == 2'h1
      && idle && !$past(cfg_wr) |-> ##2 seq_out.out_stall
      && !seq_out.osc_tune)
      else $error("divider restart did not start");
   stall_seq_a: assert property ($rose(seq_out.out_stall) |->
      !seq_out.div_reset ##SC seq_out.div_reset ##DC !seq_out.out_stall
      && !seq_out.div_reset && !seq_out.tune_busy && !seq_out.div_busy)
      else $error("stall and divider reset phases wrong");
endmodule : spcs_regs_checker
bind spcs_regs spcs_regs_checker #(.TUNE_CYCLES(TUNE_CYCLES),
   .STALL_CYCLES(STALL_CYCLES), .DIVRST_CYCLES(DIVRST_CYCLES)) chk_u (
   .clk(clk), .resetn(resetn), .soft_reset(soft_reset), .acc(acc),
   .pll_locked_in(pll_locked_in), .ref_detect_in(ref_detect_in),
   .fb_detect_in(fb_detect_in), .acc_rdata(acc_rdata),
   .acc_rvalid(acc_rvalid), .single_instr(single_instr),
   .sleep_mode(sleep_mode), .update_pulse(update_pulse),
   .seq_out(seq_out));
`default_nettype wire

// *** test/spcs_host.sv ***
// spcs_host: host model issuing register strobes to the bank.
// assumes: called from one testbench process, same clk as the bank.
`timescale 1ns/100ps
`default_nettype none
`include "spcs_defs.svh"
module spcs_host (
   input wire logic clk,
   output var spcs_pkg::spcs_acc_t acc,
   input wire logic [7:0] acc_rdata,
   input wire logic acc_rvalid
);
   initial acc = '0;
   // reserved bits forced to zero; released bus shows inverted values
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = d;
      if (a == `SPCS_ADDR_CFG2) m = d & 8'ha6;
      if (a == `SPCS_ADDR_STAT) m = d & 8'hf3;
      @(posedge clk);
      acc <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: m};
      @(posedge clk);
      acc <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~m};
   endtask : wr
   // answer is read 1 ns after the taking edge, one cycle after the strobe is driven
   task automatic rd(input logic [11:0] a, output logic [7:0] d,
      output bit ok);
      @(posedge clk);
      acc <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~acc.wdata};
      @(posedge clk);
      acc <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~acc.wdata};
      #1;
      ok = (acc_rvalid === 1'b1);
      d = acc_rdata;
   endtask : rd
endmodule : spcs_host
`default_nettype wire

// *** test/testbench.sv ***
// testbench: table of accesses, then sequencer, detector, reset cases.
// assumes: short sequencer counts keep the run brief.
`timescale 1ns/100ps
`default_nettype none
`include "spcs_defs.svh"
module testbench;
   typedef struct packed {
      logic [11:0] wa;
      logic [7:0] wd;
      logic [11:0] ra;
      logic [7:0] er;
      logic [1:0] es;
   } spcs_row_t;
   localparam spcs_row_t ROWS [14] = '{
      '{12'h0ab, 8'hff, 12'h002, 8'hf0, 2'h0},
      '{12'h001, 8'h80, 12'h001, 8'h80, 2'h0},
      '{12'h001, 8'h00, 12'h001, 8'h00, 2'h0},
      '{12'h002, 8'h03, 12'h002, 8'hf0, 2'h0},
      '{12'h00f, 8'h01, 12'h002, 8'hf3, 2'h3},
      '{12'h002, 8'h00, 12'h002, 8'hf3, 2'h3},
      '{12'h00f, 8'h01, 12'h002, 8'hf0, 2'h0},
      '{12'h001, 8'h20, 12'h001, 8'h00, 2'h0},
      '{12'h00f, 8'h01, 12'h001, 8'h20, 2'h0},
      '{12'h002, 8'h03, 12'h002, 8'hf3, 2'h0},
      '{12'h001, 8'h00, 12'h001, 8'h00, 2'h0},
      '{12'h00f, 8'h01, 12'h002, 8'hf3, 2'h3},
      '{12'h002, 8'h00, 12'h002, 8'hf3, 2'h3},
      '{12'h00f, 8'h01, 12'h0ab, 8'h00, 2'h0}};
   logic clk, resetn, soft_reset, lock_in, ref_in, fb_in;
   logic acc_rvalid, single_instr, update_pulse, saw_tune, saw_stall;
   logic [7:0] acc_rdata, rd_d;
   logic [1:0] sleep_mode;
   spcs_pkg::spcs_acc_t acc;
   spcs_pkg::spcs_seq_out_t seq_out;
   int mismatches, n_tests, i;
   bit ok;
   spcs_regs #(.TUNE_CYCLES(8'h08), .STALL_CYCLES(8'h02),
      .DIVRST_CYCLES(8'h04)) dut_u (.clk(clk), .resetn(resetn),
      .soft_reset(soft_reset), .acc(acc), .pll_locked_in(lock_in),
      .ref_detect_in(ref_in), .fb_detect_in(fb_in), .acc_rdata(acc_rdata),
      .acc_rvalid(acc_rvalid), .single_instr(single_instr),
      .sleep_mode(sleep_mode), .update_pulse(update_pulse),
      .seq_out(seq_out));
   spcs_host host_u (.clk(clk), .acc(acc), .acc_rdata(acc_rdata),
      .acc_rvalid(acc_rvalid));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdc(input string nm, input logic [11:0] a,
      input logic [7:0] e);
      host_u.rd(a, rd_d, ok);
      chk({nm, " valid"}, 8'h01, {7'h0, ok});
      chk(nm, e, rd_d);
   endtask : rdc
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // one tune or restart request, then a bounded wait for the sequencer to finish
   task automatic seq_run(input logic [7:0] d, input logic t_exp);
      saw_tune = 1'b0;
      saw_stall = 1'b0;
      host_u.wr(`SPCS_ADDR_CFG2, d);
      rdc("busy bits", `SPCS_ADDR_CFG2, t_exp ? 8'h04 : 8'h02);
      // phases sampled off the edge, once a clock, until both busy drop
      for (i = 0; i < 100 && (seq_out.tune_busy !== 1'b0
         || seq_out.div_busy !== 1'b0); i++) begin
         if (seq_out.osc_tune === 1'b1) saw_tune = 1'b1;
         if (seq_out.out_stall === 1'b1) saw_stall = 1'b1;
         @(posedge clk);
         #1;
      end
      if (i == 100) begin
         mismatches++;
         test_done();
      end
      chk("tune seen", {7'h0, t_exp}, {7'h0, saw_tune});
      chk("stall seen", 8'h01, {7'h0, saw_stall});
      rdc("self clear", `SPCS_ADDR_CFG2, 8'h00);
   endtask : seq_run
   initial begin
      resetn = 1'b0;
      soft_reset = 1'b0;
      {lock_in, ref_in, fb_in} = 3'h7;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int r = 0; r < 14; r++) begin
         host_u.wr(ROWS[r].wa, ROWS[r].wd);
         rdc("row read", ROWS[r].ra, ROWS[r].er);
         chk("sleep", {6'h0, ROWS[r].es}, {6'h0, sleep_mode});
      end
      $display("table done");
      seq_run(8'h04, 1'b1);
      seq_run(8'h02, 1'b0);
      $display("sequencer done");
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         {lock_in, ref_in, fb_in} <= k[2:0];
         repeat (6) @(posedge clk);
         rdc("status", `SPCS_ADDR_STAT,
            {k[2:0], k[1] & k[0], 4'h0});
      end
      $display("detectors done");
      host_u.wr(`SPCS_ADDR_CFG2, 8'h80);
      #1;
      chk("single on", 8'h01, {7'h0, single_instr});
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rdc("soft reset", `SPCS_ADDR_CFG2, 8'h00);
      host_u.wr(`SPCS_ADDR_STAT, 8'h03);
      host_u.wr(`SPCS_ADDR_UPD, 8'h01);
      #1;
      chk("update pulse", 8'h01, {7'h0, update_pulse});
      chk("sleep on", 8'h03, {6'h0, sleep_mode});
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("sleep reset", 8'h00, {6'h0, sleep_mode});
      // detector sync flops refill before the status read
      repeat (3) @(posedge clk);
      rdc("status reset", `SPCS_ADDR_STAT, 8'hf0);
      rdc("config reset", `SPCS_ADDR_CFG2, 8'h00);
      $display("reset done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
